// *** core/anp_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module anp_regs
    import anp_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Serial management pins.
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n,
    input wire logic [4:0] phy_addr,
    // Status from the negotiation engine.
    input wire logic partner_an_able,
    input wire logic partner_np_able,
    input wire logic pd_fault,
    input wire logic page_rx_evt,
    input wire anp_page_type rx_page,
    input wire logic tx_word_sent,
    // Outgoing next page to the negotiation engine.
    output anp_page_type tx_page
);

    anp_req_type req;
    logic [15:0] rdata;
    logic pd_flag;
    logic page_flag;
    anp_page_type txnp_r;
    anp_page_type txnp_nxt;
    anp_page_type pnp_r;
    anp_page_type pnp_nxt;
    anp_page_type wr_page;
    anp_page_type rx_clean;
    logic [15:0] exp_word;

    // Decoded accesses.
    wire rd_exp = req.rd && (req.addr == ANP_REG_EXP);
    wire wr_txnp = req.wr && (req.addr == ANP_REG_TXNP);
    wire sel_exp = req.addr == ANP_REG_EXP;
    wire sel_txnp = req.addr == ANP_REG_TXNP;
    wire sel_pnp = req.addr == ANP_REG_PNP;

    anp_mdio_slave u_mdio (
        .mclk(mclk),
        .arst_n(arst_n),
        .mdc(mdc),
        .mdio_i(mdio_i),
        .mdio_o(mdio_o),
        .mdio_oe_n(mdio_oe_n),
        .phy_addr(phy_addr),
        .req(req),
        .rdata(rdata)
    );

    // Parallel detection fault, latched until the expansion register is read.
    anp_lh_flag u_pd_flag (
        .mclk(mclk),
        .arst_n(arst_n),
        .set(pd_fault),
        .clr(rd_exp),
        .flag_r(pd_flag)
    );

    // Page received, set by each arriving next page.
    anp_lh_flag u_page_flag (
        .mclk(mclk),
        .arst_n(arst_n),
        .set(page_rx_evt),
        .clr(rd_exp),
        .flag_r(page_flag)
    );

    // Expansion status word; upper bits stay zero.
    assign exp_word = {11'h000, pd_flag, partner_np_able,
        ANP_LOCAL_NP_VALUE, page_flag, partner_an_able};

    // Read data multiplexer; other addresses read zero.
    assign rdata = sel_exp ? exp_word :
        sel_txnp ? 16'(txnp_r) :
        sel_pnp ? 16'(pnp_r) : 16'h0000;

    // Software fields of the transmit page; reserved bit stays zero.
    assign wr_page = anp_clean_page(req.wdata);

    // The toggle is kept from writes and flips for each sent word.
    always_comb begin
        txnp_nxt = txnp_r;
        if (wr_txnp) begin
            txnp_nxt = wr_page;
        end
        txnp_nxt.toggle = tx_word_sent ? ~txnp_r.toggle
            : txnp_r.toggle;
    end

    // Partner page captured on arrival.
    assign rx_clean = anp_clean_page(rx_page);
    assign pnp_nxt = page_rx_evt ? rx_clean : pnp_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            txnp_r <= ANP_TXNP_RESET;
            pnp_r <= ANP_PNP_RESET;
        end else begin
            txnp_r <= txnp_nxt;
            pnp_r <= pnp_nxt;
        end
    end

    assign tx_page = txnp_r;

    // Checks on the register bank.
    exp_upper_zero_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        sel_exp |-> rdata[15:5] == 11'h000
    ) else $error("Expansion upper bits not zero.");

    pd_fault_latch_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        pd_fault |=> rdata[ANP_EXP_PD_FAULT] || !sel_exp
    ) else $error("Parallel fault not latched.");

    partner_an_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        sel_exp |-> rdata[ANP_EXP_PARTNER_AN] == partner_an_able
    ) else $error("Partner ability bit wrong.");

    page_rx_latch_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        page_rx_evt |=> page_flag
    ) else $error("Page received not latched.");

    local_np_one_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        sel_exp |-> rdata[ANP_EXP_LOCAL_NP]
    ) else $error("Local next page bit not one.");

    partner_np_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        sel_exp |-> rdata[ANP_EXP_PARTNER_NP] == partner_np_able
    ) else $error("Partner next page bit wrong.");

    tx_write_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        wr_txnp |=> tx_page.more == $past(req.wdata[ANP_NP_MORE])
            && tx_page.msg == $past(req.wdata[ANP_NP_MSG])
    ) else $error("Page control bits not written.");

    ack2_write_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        wr_txnp |=> tx_page.ack2 == $past(req.wdata[ANP_NP_ACK2])
    ) else $error("Second acknowledge not written.");

    toggle_flip_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        tx_word_sent |=> tx_page.toggle != $past(tx_page.toggle)
    ) else $error("Toggle did not flip.");

    toggle_hold_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !tx_word_sent |=> $stable(tx_page.toggle)
    ) else $error("Toggle changed without a sent word.");

    code_write_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        wr_txnp |=> tx_page.code == $past(req.wdata[ANP_NP_CODE_MSB:0])
            && !tx_page.rsvd
    ) else $error("Code field not written.");

    pnp_capture_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        page_rx_evt |=> pnp_r == anp_clean_page($past(rx_page))
    ) else $error("Partner page not captured.");

    pnp_hold_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !page_rx_evt |=> $stable(pnp_r)
    ) else $error("Partner page changed by itself.");

    flag_hold_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        page_flag && !rd_exp |=> page_flag
    ) else $error("Latched flag lost without a read.");

    flag_clear_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        rd_exp && !page_rx_evt && !pd_fault |=> !page_flag && !pd_flag
    ) else $error("Latched flags not cleared by read.");

endmodule

`default_nettype wire

// *** core/anp_pkg.sv ***
// Overview of operation
// - The expansion status register is read-only, shows partner auto-negotiation ability in bit 0 and a latched parallel-detection fault in bit 4, and reads zero in bits 15 to 5.
// - The page-received flag in bit 1 latches high when a next page arrives from the partner, is zero otherwise and resets to zero.
// - The local next-page ability flag in bit 2 always reads one, including straight after reset.
// - The partner next-page ability flag in bit 3 reads one only while the partner reports next-page ability and resets to zero.
// - In the transmit page, software writes bit 15 as zero for the last page or one when more follow, and bit 13 as one for a message page or zero for an unformatted one; they reset to zero and one.
// - Software writes the second-acknowledge bit 12 as one when it can comply with the received message and zero otherwise; it resets to zero.
// - The toggle bit 11 of the transmit page is read-only and driven by the device as the opposite of the previous sent code word's toggle; it resets to zero.
// - Software loads the eleven-bit code field in bits 10 to 0, which resets to zero except bit 0, which resets to one.
// - The partner next-page register is read-only, holds the received page's fields in the same positions as the transmit page and resets to zero.

package anp_pkg;

    // Register addresses on the management bus.
    localparam logic [4:0] ANP_REG_EXP = 5'h06;
    localparam logic [4:0] ANP_REG_TXNP = 5'h07;
    localparam logic [4:0] ANP_REG_PNP = 5'h08;

    // Bit positions of the expansion status register.
    localparam int ANP_EXP_PD_FAULT = 4;
    localparam int ANP_EXP_PARTNER_NP = 3;
    localparam int ANP_EXP_LOCAL_NP = 2;
    localparam int ANP_EXP_PAGE_RX = 1;
    localparam int ANP_EXP_PARTNER_AN = 0;
    localparam logic ANP_LOCAL_NP_VALUE = 1'b1;

    // Bit positions of a next page word.
    localparam int ANP_NP_MORE = 15;
    localparam int ANP_NP_RSVD = 14;
    localparam int ANP_NP_MSG = 13;
    localparam int ANP_NP_ACK2 = 12;
    localparam int ANP_NP_TOGGLE = 11;
    localparam int ANP_NP_CODE_MSB = 10;

    // Management frame framing.
    localparam logic [5:0] ANP_PRE_BITS = 6'h20;
    localparam logic [5:0] ANP_HDR_LAST = 6'h0C;
    localparam logic [5:0] ANP_TA_LAST = 6'h01;
    localparam logic [5:0] ANP_DATA_LAST = 6'h0F;
    localparam logic [1:0] ANP_OP_READ = 2'h2;
    localparam logic [1:0] ANP_OP_WRITE = 2'h1;

    typedef struct packed {
        logic more;
        logic rsvd;
        logic msg;
        logic ack2;
        logic toggle;
        logic [10:0] code;
    } anp_page_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } anp_req_type;

    typedef enum logic [1:0] {
        ANP_PRE,
        ANP_HDR,
        ANP_TA,
        ANP_DATA
    } anp_mdio_state_type;

    localparam anp_page_type ANP_TXNP_RESET = 16'h2001;
    localparam anp_page_type ANP_PNP_RESET = 16'h0000;
    localparam anp_req_type ANP_REQ_RESET = 23'h000000;

    // Turns a raw word into a page with the reserved bit forced to zero.
    function automatic anp_page_type anp_clean_page(input logic [15:0] w);
        anp_page_type p;
        p = w;
        p.rsvd = 1'b0;
        return p;
    endfunction

endpackage

// *** core/anp_lh_flag.sv ***
`timescale 1ns/1ps
`default_nettype none

module anp_lh_flag (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Cause and read strobe.
    input wire logic set,
    input wire logic clr,
    // Latched state.
    output logic flag_r
);

    logic flag_nxt;

    // A cause in the clearing cycle wins over the read.
    assign flag_nxt = set | (flag_r & ~clr);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule

`default_nettype wire

// *** core/anp_mdio_slave.sv ***
`timescale 1ns/1ps
`default_nettype none

module anp_mdio_slave
    import anp_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Management pins.
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n,
    input wire logic [4:0] phy_addr,
    // Register side.
    output anp_req_type req,
    input wire logic [15:0] rdata
);

    anp_mdio_state_type state_r;
    logic mdc_q;
    logic [5:0] cnt_r;
    logic [15:0] sh_r;
    logic is_rd_r;
    anp_req_type req_r;

    wire mdc_rise = mdc & ~mdc_q;
    wire [12:0] hdr = {sh_r[11:0], mdio_i};
    wire [1:0] hdr_op = hdr[11:10];
    wire hdr_ok = hdr[12] && (hdr[9:5] == phy_addr);
    wire hdr_rd = hdr_ok && (hdr_op == ANP_OP_READ);
    wire hdr_wr = hdr_ok && (hdr_op == ANP_OP_WRITE);
    wire [5:0] cnt_inc = cnt_r + 6'h01;

    assign req = req_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ANP_PRE;
            mdc_q <= 1'b0;
            cnt_r <= 6'h00;
            sh_r <= 16'h0000;
            is_rd_r <= 1'b0;
            req_r <= ANP_REQ_RESET;
            mdio_o <= 1'b0;
            mdio_oe_n <= 1'b1;
        end else begin
            mdc_q <= mdc;
            req_r.rd <= 1'b0;
            req_r.wr <= 1'b0;
            if (req_r.rd) begin
                sh_r <= rdata;
            end
            if (mdc_rise) begin
                unique case (state_r)
                    ANP_PRE: begin
                        if (mdio_i) begin
                            if (cnt_r != ANP_PRE_BITS) begin
                                cnt_r <= cnt_inc;
                            end
                        end else if (cnt_r == ANP_PRE_BITS) begin
                            state_r <= ANP_HDR;
                            cnt_r <= 6'h00;
                        end else begin
                            cnt_r <= 6'h00;
                        end
                    end
                    ANP_HDR: begin
                        sh_r <= {sh_r[14:0], mdio_i};
                        cnt_r <= cnt_inc;
                        if (cnt_r == ANP_HDR_LAST) begin
                            cnt_r <= 6'h00;
                            is_rd_r <= hdr_rd;
                            req_r.addr <= hdr[4:0];
                            req_r.rd <= hdr_rd;
                            state_r <= (hdr_rd || hdr_wr) ? ANP_TA : ANP_PRE;
                        end
                    end
                    ANP_TA: begin
                        cnt_r <= cnt_inc;
                        if (is_rd_r) begin
                            mdio_oe_n <= 1'b0;
                        end
                        if (cnt_r == ANP_TA_LAST) begin
                            state_r <= ANP_DATA;
                            cnt_r <= 6'h00;
                            if (is_rd_r) begin
                                mdio_o <= sh_r[15];
                                sh_r <= {sh_r[14:0], 1'b0};
                            end
                        end
                    end
                    ANP_DATA: begin
                        cnt_r <= cnt_inc;
                        if (is_rd_r) begin
                            mdio_o <= sh_r[15];
                            sh_r <= {sh_r[14:0], 1'b0};
                        end else begin
                            sh_r <= {sh_r[14:0], mdio_i};
                        end
                        if (cnt_r == ANP_DATA_LAST) begin
                            state_r <= ANP_PRE;
                            cnt_r <= 6'h00;
                            mdio_oe_n <= 1'b1;
                            mdio_o <= 1'b0;
                            if (!is_rd_r) begin
                                req_r.wr <= 1'b1;
                                req_r.wdata <= {sh_r[14:0], mdio_i};
                            end
                        end
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// *** bench/anp_sta_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module anp_sta_model (
    // Clock.
    input wire logic mclk,
    // Management pins seen from the controller.
    output logic mdc,
    output logic mdio_wire,
    input wire logic mdio_o,
    input wire logic mdio_oe_n
);
    logic drv_en;
    logic drv_bit;

    // The data line has a pull-up, so it reads one when nobody drives it.
    assign mdio_wire = !mdio_oe_n ? mdio_o : (drv_en ? drv_bit : 1'b1);

    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b1;
    end

    task automatic half_wait();
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // Sends one frame; rd holds the bits sampled before rises 49 to 64.
    task automatic frame(input logic [1:0] op, input logic [4:0] pa,
            input logic [4:0] ra, input logic [15:0] wd,
            output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hFFFF_FFFF, 2'h1, op, pa, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            drv_en = !(op == 2'h2 && i >= 46);
            drv_bit = bits[63 - i];
            half_wait();
            if (i >= 48) begin
                rd[63 - i] = mdio_wire;
            end
            mdc = 1'b1;
            half_wait();
            mdc = 1'b0;
        end
        drv_en = 1'b0;
        half_wait();
    endtask
endmodule

`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import anp_pkg::*;
;
    typedef struct packed {
        logic [1:0] op;
        logic [4:0] ra;
        logic [15:0] wd;
        logic [15:0] exp;
    } anp_tb_row_type;

    localparam logic [4:0] MY_ADDR = 5'h05;
    localparam logic [1:0] RD = ANP_OP_READ;
    localparam logic [1:0] WR = ANP_OP_WRITE;

    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic mdc;
    logic mdio_wire;
    logic mdio_o;
    logic mdio_oe_n;
    logic an_able = 1'b0;
    logic np_able = 1'b0;
    logic pd_fault = 1'b0;
    logic page_rx_evt = 1'b0;
    logic tx_word_sent = 1'b0;
    anp_page_type rx_page = 16'h0000;
    anp_page_type tx_page;
    int bad_count = 0;
    int comparisons = 0;

    // Reads give the register value, writes the expected outgoing page.
    anp_tb_row_type rows [11] = '{
        {RD, 5'h07, 16'h0000, 16'h2001},
        {RD, 5'h06, 16'h0000, 16'h0004},
        {RD, 5'h08, 16'h0000, 16'h0000},
        {WR, 5'h07, 16'hFFFF, 16'hB7FF},
        {RD, 5'h07, 16'h0000, 16'hB7FF},
        {WR, 5'h07, 16'h0000, 16'h0000},
        {RD, 5'h1F, 16'h0000, 16'h0000},
        {WR, 5'h06, 16'hFFFF, 16'h0000},
        {RD, 5'h06, 16'h0000, 16'h0004},
        {WR, 5'h08, 16'hFFFF, 16'h0000},
        {RD, 5'h08, 16'h0000, 16'h0000}
    };

    always #2.5 mclk = ~mclk;

    anp_sta_model STA (
        .mclk(mclk),
        .mdc(mdc),
        .mdio_wire(mdio_wire),
        .mdio_o(mdio_o),
        .mdio_oe_n(mdio_oe_n)
    );

    anp_regs DUT (
        .mclk(mclk),
        .arst_n(arst_n),
        .mdc(mdc),
        .mdio_i(mdio_wire),
        .mdio_o(mdio_o),
        .mdio_oe_n(mdio_oe_n),
        .phy_addr(MY_ADDR),
        .partner_an_able(an_able),
        .partner_np_able(np_able),
        .pd_fault(pd_fault),
        .page_rx_evt(page_rx_evt),
        .rx_page(rx_page),
        .tx_word_sent(tx_word_sent),
        .tx_page(tx_page)
    );

    task automatic test_done();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp_v,
            input logic [15:0] got);
        comparisons++;
        if (got !== exp_v) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp_v, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp_v);
        logic [15:0] v;
        STA.frame(RD, MY_ADDR, ra, 16'h0000, v);
        check("read_data", exp_v, v);
    endtask

    task automatic wr_reg(input logic [4:0] pa, input logic [4:0] ra,
            input logic [15:0] wd);
        logic [15:0] v;
        STA.frame(WR, pa, ra, wd, v);
        step(3);
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        $display("wrong value cycle_limit expected done seen timeout");
        test_done();
    end

    initial begin
        anp_tb_row_type r;
        logic [15:0] v;
        step(4);
        arst_n = 1'b1;
        check("tx_page", 16'h2001, tx_page);
        check("oe_n", 16'h0001, {15'h0000, mdio_oe_n});
        step(1);
        for (int i = 0; i < 11; i++) begin
            r = rows[i];
            if (r.op == RD) begin
                rd_reg(r.ra, r.exp);
            end else begin
                wr_reg(MY_ADDR, r.ra, r.wd);
                check("tx_page", r.exp, tx_page);
            end
        end
        $display("test table done");
        an_able = 1'b1;
        np_able = 1'b1;
        rd_reg(5'h06, 16'h000D);
        an_able = 1'b0;
        np_able = 1'b0;
        $display("test live_bits done");
        rx_page = 16'hFFFF;
        page_rx_evt = 1'b1;
        step(1);
        page_rx_evt = 1'b0;
        rd_reg(5'h06, 16'h0006);
        rd_reg(5'h06, 16'h0004);
        rd_reg(5'h08, 16'hBFFF);
        $display("test page_received done");
        pd_fault = 1'b1;
        rd_reg(5'h06, 16'h0014);
        pd_fault = 1'b0;
        rd_reg(5'h06, 16'h0014);
        rd_reg(5'h06, 16'h0004);
        $display("test fault_latch done");
        tx_word_sent = 1'b1;
        step(1);
        tx_word_sent = 1'b0;
        step(1);
        check("tx_page", 16'h0800, tx_page);
        wr_reg(MY_ADDR, 5'h07, 16'h2001);
        rd_reg(5'h07, 16'h2801);
        $display("test toggle done");
        STA.frame(RD, MY_ADDR ^ 5'h01, 5'h07, 16'h0000, v);
        check("other_addr", 16'hFFFF, v);
        wr_reg(MY_ADDR ^ 5'h01, 5'h07, 16'h0000);
        STA.frame(2'h3, MY_ADDR, 5'h07, 16'h0000, v);
        step(3);
        check("tx_page", 16'h2801, tx_page);
        rd_reg(5'h07, 16'h2801);
        $display("test other_address done");
        page_rx_evt = 1'b1;
        step(1);
        page_rx_evt = 1'b0;
        arst_n = 1'b0;
        step(1);
        check("tx_page", 16'h2001, tx_page);
        arst_n = 1'b1;
        step(1);
        rd_reg(5'h06, 16'h0004);
        rd_reg(5'h08, 16'h0000);
        $display("test mid_reset done");
        test_done();
    end
endmodule

`default_nettype wire
